// ===== design/scr_pkg.sv
// Constants and encodings shared by the serial control register bank.
package scr_pkg;

  // Frame layout: flag edge, address edges, then data edges.
  localparam int unsigned SCR_FLAG_EDGES = 1;
  localparam int unsigned SCR_ADDR_BITS = 3;
  localparam logic [3:0] SCR_HDR_EDGES = 4'h4;
  localparam logic [3:0] SCR_MAX_EDGES = 4'hE;
  localparam logic [3:0] SCR_FULL_BITS = 4'hA;
  localparam logic [3:0] SCR_AUX_BITS = 4'h8;
  localparam logic [3:0] SCR_CNT_ZERO = 4'h0;
  localparam logic [3:0] SCR_CNT_ONE = 4'h1;

  // Register addresses carried in the frame header.
  localparam logic [2:0] SCR_ADDR_MODE = 3'h0;
  localparam logic [2:0] SCR_ADDR_OUT_MODE = 3'h1;
  localparam logic [2:0] SCR_ADDR_MISC = 3'h2;
  localparam logic [2:0] SCR_ADDR_POWER = 3'h3;
  localparam logic [2:0] SCR_ADDR_CLAMP = 3'h4;
  localparam logic [2:0] SCR_ADDR_GAIN = 3'h5;
  localparam logic [2:0] SCR_ADDR_AUX1 = 3'h6;
  localparam logic [2:0] SCR_ADDR_AUX2 = 3'h7;

  // Bit positions inside the combined single-bit register and the gain register.
  localparam int unsigned SCR_MISC_OFS_BIT = 0;
  localparam int unsigned SCR_MISC_GSRC_BIT = 1;
  localparam int unsigned SCR_MISC_DACPWR_BIT = 2;
  localparam int unsigned SCR_GAIN_AUX_LSB = 2;

  // Reset values.
  localparam logic [1:0] SCR_MODE_RESET = 2'h3;
  localparam logic [1:0] SCR_CODE2_RESET = 2'h0;
  localparam logic [9:0] SCR_GAIN_RESET = 10'h000;
  localparam logic [7:0] SCR_CODE8_RESET = 8'h00;
  localparam logic SCR_BIT_RESET = 1'b0;

  // Operating mode codes.
  localparam logic [1:0] SCR_MODE_ADC = 2'h0;
  localparam logic [1:0] SCR_MODE_AUX = 2'h1;

  // Output mode codes and their fixed patterns.
  localparam logic [1:0] SCR_OUT_NORMAL = 2'h0;
  localparam logic [1:0] SCR_OUT_PAT_A = 2'h1;
  localparam logic [1:0] SCR_OUT_PAT_B = 2'h2;
  localparam logic [1:0] SCR_OUT_HIZ = 2'h3;
  localparam logic [9:0] SCR_PATTERN_A = 10'h155;
  localparam logic [9:0] SCR_PATTERN_B = 10'h2AA;
  localparam logic [9:0] SCR_PATTERN_NONE = 10'h000;

  // Power mode codes.
  localparam logic [1:0] SCR_PWR_HIGH_SPEED = 2'h1;
  localparam logic [1:0] SCR_PWR_STANDBY = 2'h2;
  localparam logic [1:0] SCR_PWR_SHUTDOWN = 2'h3;

  // Clamp level codes and black targets in LSBs.
  localparam logic [1:0] SCR_CLAMP_C0 = 2'h0;
  localparam logic [1:0] SCR_CLAMP_C1 = 2'h1;
  localparam logic [1:0] SCR_CLAMP_C2 = 2'h2;
  localparam logic [6:0] SCR_CLAMP_LSB_C0 = 7'h20;
  localparam logic [6:0] SCR_CLAMP_LSB_C1 = 7'h30;
  localparam logic [6:0] SCR_CLAMP_LSB_C2 = 7'h40;
  localparam logic [6:0] SCR_CLAMP_LSB_C3 = 7'h10;

endpackage

// ===== design/scr_pin_sync.sv
// Two-stage synchroniser for the three serial port input pins.
module scr_pin_sync
  import scr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [2:0] pin_async,
  output logic [2:0] pin_sync
);

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;

  // Reset value is idle select high; the first stage feeds only the second.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      meta_reg <= 3'h1;
      sync_reg <= 3'h1;
    end
    else
    begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;

endmodule

// ===== design/scr_serial_regs.sv
// Serial control register bank with three-wire port and decoded controls.
//
// Overview of operation
// - Auxiliary gain code is gain upper eight bits.
// - Eight-bit first auxiliary converter code, reset zero.
// - Eight-bit second auxiliary converter code, reset zero.
// - One bit enables even/odd offset correction.
// - Gain source: 0 external pins, 1 internal.
// - Auxiliary converters powered down at 0, on at 1.
// - Eight-bit gain write accepted in auxiliary mode.
// - Shift clock edges after the fourteenth ignored.
// - All registers reset zero, mode resets eleven.
// - Mode 00 direct, 01 auxiliary, else sensor.
// - Output mode normal, 0101, 1010, high impedance.
// - Power normal, high speed, standby, shutdown.
// - Clamp target 32, 48, 64, 16 LSBs.
module scr_serial_regs
  import scr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic serial_select_line,
  input wire logic serial_shift_clock,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  output logic [1:0] operating_mode,
  output logic [1:0] output_mode,
  output logic [1:0] power_mode,
  output logic [1:0] clamp_level,
  output logic [9:0] gain_code,
  output logic [7:0] first_aux_output_code,
  output logic [7:0] second_aux_output_code,
  output logic offset_correction_enable,
  output logic gain_source_select,
  output logic aux_converter_power,
  output logic image_sensor_mode,
  output logic aux_video_mode,
  output logic direct_adc_mode,
  output logic [7:0] aux_gain_code,
  output logic test_pattern_enable,
  output logic [9:0] test_pattern,
  output logic data_outputs_hiz,
  output logic high_speed_aux,
  output logic reference_standby,
  output logic total_shutdown,
  output logic [6:0] clamp_target_lsb
);

  typedef struct packed {
    logic sel_d;
    logic sck_d;
    logic [3:0] cnt;
    logic read_write_flag;
    logic [2:0] addr;
    logic [9:0] data;
    logic sdo;
    logic sdo_oe;
    logic [1:0] mode;
    logic [1:0] omode;
    logic [1:0] power;
    logic [1:0] clamp;
    logic [9:0] gain;
    logic [7:0] aux1;
    logic [7:0] aux2;
    logic ofs;
    logic gsrc;
    logic dacpwr;
    logic img;
    logic auxm;
    logic adcm;
    logic pat_en;
    logic [9:0] pat;
    logic hiz;
    logic hspd;
    logic standby_pin;
    logic shdn;
    logic [6:0] clamp_lsb;
  } scr_state_t;

  scr_state_t st_reg;
  scr_state_t st_next;
  logic [2:0] pins_s;
  logic sel_s;
  logic sck_s;
  logic sda_s;

  // Decoded controls follow the register fields in the same cycle.
  function automatic scr_state_t scr_decode(input scr_state_t s);
    scr_state_t r;
    r = s;
    r.auxm = (s.mode == SCR_MODE_AUX);
    r.adcm = (s.mode == SCR_MODE_ADC);
    r.img = !r.auxm && !r.adcm;
    r.pat_en = (s.omode == SCR_OUT_PAT_A) || (s.omode == SCR_OUT_PAT_B);
    r.pat = (s.omode == SCR_OUT_PAT_A) ? SCR_PATTERN_A :
      (s.omode == SCR_OUT_PAT_B) ? SCR_PATTERN_B : SCR_PATTERN_NONE;
    r.hiz = (s.omode == SCR_OUT_HIZ);
    r.hspd = (s.power == SCR_PWR_HIGH_SPEED);
    r.standby_pin = (s.power == SCR_PWR_STANDBY);
    r.shdn = (s.power == SCR_PWR_SHUTDOWN);
    case (s.clamp)
      SCR_CLAMP_C0: r.clamp_lsb = SCR_CLAMP_LSB_C0;
      SCR_CLAMP_C1: r.clamp_lsb = SCR_CLAMP_LSB_C1;
      SCR_CLAMP_C2: r.clamp_lsb = SCR_CLAMP_LSB_C2;
      default: r.clamp_lsb = SCR_CLAMP_LSB_C3;
    endcase
    return r;
  endfunction

  // Power-on contents: everything zero except the operating mode, the decoded img and clamp_lsb, and the select history bit, which starts high.
  function automatic scr_state_t scr_reset_state();
    scr_state_t r;
    r = '0;
    r.sel_d = 1'b1;
    r.mode = SCR_MODE_RESET;
    r.omode = SCR_CODE2_RESET;
    r.power = SCR_CODE2_RESET;
    r.clamp = SCR_CODE2_RESET;
    r.gain = SCR_GAIN_RESET;
    r.aux1 = SCR_CODE8_RESET;
    r.aux2 = SCR_CODE8_RESET;
    r.ofs = SCR_BIT_RESET;
    r.gsrc = SCR_BIT_RESET;
    r.dacpwr = SCR_BIT_RESET;
    return scr_decode(r);
  endfunction

  // The pins come from another domain, so they are synchronised first.
  scr_pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_async({serial_data_line_in, serial_shift_clock, serial_select_line}),
    .pin_sync(pins_s)
  );

  assign sel_s = pins_s[0];
  assign sck_s = pins_s[1];
  assign sda_s = pins_s[2];

  // Readback word for the address held in a state; unused high bits read as zero.
  // It is called inside the frame engine, so no second process feeds back into it.
  function automatic logic [9:0] scr_read_word(input scr_state_t s);
    logic [9:0] w;
    unique case (s.addr)
      SCR_ADDR_MODE: w = {8'h00, s.mode};
      SCR_ADDR_OUT_MODE: w = {8'h00, s.omode};
      SCR_ADDR_MISC: w = {7'h00, s.dacpwr, s.gsrc, s.ofs};
      SCR_ADDR_POWER: w = {8'h00, s.power};
      SCR_ADDR_CLAMP: w = {8'h00, s.clamp};
      SCR_ADDR_GAIN: w = s.gain;
      SCR_ADDR_AUX1: w = {2'h0, s.aux1};
      SCR_ADDR_AUX2: w = {2'h0, s.aux2};
    endcase
    return w;
  endfunction

  // Frame engine: edge detection, shifting, readback drive and commit.
  always_comb
  begin
    logic [3:0] nbits;
    logic [3:0] idx;
    logic sck_rise;
    logic sel_rise;
    logic [9:0] rd_word;
    nbits = SCR_CNT_ZERO;
    idx = SCR_CNT_ZERO;
    rd_word = '0;
    st_next = st_reg;
    sck_rise = sck_s && !st_reg.sck_d;
    sel_rise = sel_s && !st_reg.sel_d;
    st_next.sel_d = sel_s;
    st_next.sck_d = sck_s;
    // A write lands only when select rises; a frame cut short of its data is dropped unless it is a gain write of eight or more bits in auxiliary mode.
    if (sel_rise && !st_reg.read_write_flag && st_reg.cnt >= SCR_HDR_EDGES)
    begin
      nbits = st_reg.cnt - SCR_HDR_EDGES;
      if (nbits >= SCR_FULL_BITS)
      begin
        unique case (st_reg.addr)
          SCR_ADDR_MODE: st_next.mode = st_reg.data[1:0];
          SCR_ADDR_OUT_MODE: st_next.omode = st_reg.data[1:0];
          SCR_ADDR_MISC:
          begin
            st_next.ofs = st_reg.data[SCR_MISC_OFS_BIT];
            st_next.gsrc = st_reg.data[SCR_MISC_GSRC_BIT];
            st_next.dacpwr = st_reg.data[SCR_MISC_DACPWR_BIT];
          end
          SCR_ADDR_POWER: st_next.power = st_reg.data[1:0];
          SCR_ADDR_CLAMP: st_next.clamp = st_reg.data[1:0];
          SCR_ADDR_GAIN: st_next.gain = st_reg.data;
          SCR_ADDR_AUX1: st_next.aux1 = st_reg.data[7:0];
          SCR_ADDR_AUX2: st_next.aux2 = st_reg.data[7:0];
        endcase
      end
      else if (nbits >= SCR_AUX_BITS && st_reg.addr == SCR_ADDR_GAIN &&
        st_reg.mode == SCR_MODE_AUX)
      begin
        st_next.gain[9:SCR_GAIN_AUX_LSB] = st_reg.data[7:0];
      end
    end
    if (sel_s)
    begin
      // Idle: counter cleared and the data line released.
      st_next.cnt = SCR_CNT_ZERO;
      st_next.sdo_oe = 1'b0;
      st_next.sdo = 1'b0;
    end
    else if (sck_rise && st_reg.cnt < SCR_MAX_EDGES)
    begin
      if (st_reg.cnt == SCR_CNT_ZERO)
      begin
        st_next.read_write_flag = sda_s;
        st_next.data = SCR_GAIN_RESET;
      end
      else if (st_reg.cnt < SCR_HDR_EDGES)
      begin
        idx = st_reg.cnt - SCR_CNT_ONE;
        st_next.addr[idx[1:0]] = sda_s;
      end
      else
      begin
        idx = st_reg.cnt - SCR_HDR_EDGES;
        st_next.data[idx] = sda_s;
      end
      st_next.cnt = st_reg.cnt + SCR_CNT_ONE;
      // Next readback bit goes out right after the edge so it is stable by the next one.
      if (st_next.read_write_flag && st_next.cnt >= SCR_HDR_EDGES && st_next.cnt < SCR_MAX_EDGES)
      begin
        idx = st_next.cnt - SCR_HDR_EDGES;
        rd_word = scr_read_word(st_next);
        st_next.sdo = rd_word[idx];
        st_next.sdo_oe = 1'b1;
      end
      else
      begin
        st_next.sdo = 1'b0;
        st_next.sdo_oe = 1'b0;
      end
    end
    st_next = scr_decode(st_next);
  end

  // Synchronous reset stands in for the power-on reset.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      st_reg <= scr_reset_state();
    else
      st_reg <= st_next;
  end

  // Every output is a field of the state register.
  assign serial_data_line_out = st_reg.sdo;
  assign serial_data_line_oe = st_reg.sdo_oe;
  assign operating_mode = st_reg.mode;
  assign output_mode = st_reg.omode;
  assign power_mode = st_reg.power;
  assign clamp_level = st_reg.clamp;
  assign gain_code = st_reg.gain;
  assign first_aux_output_code = st_reg.aux1;
  assign second_aux_output_code = st_reg.aux2;
  assign offset_correction_enable = st_reg.ofs;
  assign gain_source_select = st_reg.gsrc;
  assign aux_converter_power = st_reg.dacpwr;
  assign image_sensor_mode = st_reg.img;
  assign aux_video_mode = st_reg.auxm;
  assign direct_adc_mode = st_reg.adcm;
  assign aux_gain_code = st_reg.gain[9:SCR_GAIN_AUX_LSB];
  assign test_pattern_enable = st_reg.pat_en;
  assign test_pattern = st_reg.pat;
  assign data_outputs_hiz = st_reg.hiz;
  assign high_speed_aux = st_reg.hspd;
  assign reference_standby = st_reg.standby_pin;
  assign total_shutdown = st_reg.shdn;
  assign clamp_target_lsb = st_reg.clamp_lsb;

endmodule

// ===== bench/scr_serial_regs_assertions.sv
// Concurrent checks on the serial control register bank ports.
module scr_serial_regs_chk
  import scr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic serial_select_line,
  input wire logic serial_data_line_oe,
  input wire logic [1:0] operating_mode,
  input wire logic [1:0] output_mode,
  input wire logic [1:0] power_mode,
  input wire logic [1:0] clamp_level,
  input wire logic [9:0] gain_code,
  input wire logic image_sensor_mode,
  input wire logic aux_video_mode,
  input wire logic direct_adc_mode,
  input wire logic [7:0] aux_gain_code,
  input wire logic test_pattern_enable,
  input wire logic [9:0] test_pattern,
  input wire logic data_outputs_hiz,
  input wire logic high_speed_aux,
  input wire logic reference_standby,
  input wire logic total_shutdown,
  input wire logic [6:0] clamp_target_lsb
);
  // Everything runs on the system clock and stays quiet while reset is held.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  aux_gain_map_a: assert property (aux_gain_code == gain_code[9:2])
    else $error("aux gain code is not the gain upper bits");
  mode_decode_a: assert property (
    {image_sensor_mode, aux_video_mode, direct_adc_mode}
    == {operating_mode[1], operating_mode == 2'h1, operating_mode == 2'h0})
    else $error("operating mode decode wrong");
  pattern_map_a: assert property (
    test_pattern == (output_mode == 2'h1 ? 10'h155 : (output_mode == 2'h2 ? 10'h2AA : 10'h000))
    && test_pattern_enable == ^output_mode && data_outputs_hiz == &output_mode)
    else $error("output mode decode wrong");
  power_decode_a: assert property (
    {high_speed_aux, reference_standby, total_shutdown}
    == {power_mode == 2'h1, power_mode == 2'h2, &power_mode})
    else $error("power mode decode wrong");
  clamp_target_a: assert property (
    clamp_target_lsb == (clamp_level[1] ? (clamp_level[0] ? 7'h10 : 7'h40)
    : (clamp_level[0] ? 7'h30 : 7'h20)))
    else $error("clamp target wrong");
  reset_values_a: assert property ($fell(sys_rst) |-> operating_mode == 2'h3 &&
    output_mode == 2'h0 && power_mode == 2'h0 && clamp_level == 2'h0 && gain_code == 10'h000)
    else $error("register not at reset value after reset");
  // Writes commit only after select rises, so a settled open frame changes nothing.
  frame_quiet_a: assert property (!serial_select_line [*4] |->
    $stable(gain_code) && $stable(operating_mode) && $stable(output_mode))
    else $error("register changed inside an open frame");
  oe_idle_a: assert property (serial_select_line [*6] |-> !serial_data_line_oe)
    else $error("data line driven outside a frame");
  cover property ($rose(serial_data_line_oe));
  cover property ($rose(aux_video_mode));
  cover property ($rose(total_shutdown));
endmodule

bind scr_serial_regs scr_serial_regs_chk chk (.clk_sys, .sys_rst, .serial_select_line,
  .serial_data_line_oe, .operating_mode, .output_mode, .power_mode, .clamp_level, .gain_code,
  .image_sensor_mode, .aux_video_mode, .direct_adc_mode, .aux_gain_code, .test_pattern_enable,
  .test_pattern, .data_outputs_hiz, .high_speed_aux, .reference_standby, .total_shutdown,
  .clamp_target_lsb);

// ===== bench/scr_host_model.sv
// Behavioural host controller that frames transfers on the three-wire serial port.
module scr_host_model (
  input wire logic clk_sys,
  input wire logic serial_data_line_wire,
  output logic serial_select_line,
  output logic serial_shift_clock,
  output logic host_data,
  output logic host_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // Select high and shift clock low from time zero, so nothing is written by accident.
  initial
  begin
    serial_select_line = 1'b1;
    serial_shift_clock = 1'b0;
    host_data = 1'b0;
    host_oe = 1'b0;
  end
  // One frame: flag, address LSB first, then nd data bits; bits past ten are ones.
  task automatic frame(input logic rd, input logic [2:0] adr, input logic [9:0] wd,
    input int nd, output logic [9:0] q);
    logic [3:0] hdr;
    hdr = {adr, rd};
    q = 10'h000;
    @(negedge clk_sys);
    serial_select_line = 1'b0;
    for (int e = 0; e < 4 + nd; e++)
    begin
      host_oe = !(rd && e >= 4);
      host_data = e < 4 ? hdr[e] : (e < 14 ? wd[e - 4] : 1'b1);
      repeat (4) @(negedge clk_sys);
      serial_shift_clock = 1'b1;
      if (rd && e >= 4)
        q[e - 4] = serial_data_line_wire;
      repeat (4) @(negedge clk_sys);
      serial_shift_clock = 1'b0;
    end
    repeat (4) @(negedge clk_sys);
    host_oe = 1'b0;
    serial_select_line = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule

// ===== bench/scr_serial_regs_tb.sv
// Self-checking bench for the serial control register bank.
module scr_serial_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed { logic [2:0] a; logic [9:0] d; logic [9:0] r; } scr_row_t;
  logic clk_sys, serial_select_line, serial_shift_clock, serial_data_line_in, host_data;
  logic serial_data_line_out, serial_data_line_oe, host_oe, sys_rst = 1'b1, idle_toggle = 1'b0;
  logic [1:0] operating_mode, output_mode, power_mode, clamp_level;
  logic [9:0] gain_code, test_pattern, q;
  logic [7:0] first_aux_output_code, second_aux_output_code, aux_gain_code;
  logic offset_correction_enable, gain_source_select, aux_converter_power, image_sensor_mode;
  logic aux_video_mode, direct_adc_mode, test_pattern_enable, data_outputs_hiz;
  logic high_speed_aux, reference_standby, total_shutdown;
  logic [6:0] clamp_target_lsb;
  logic [9:0] shadow [8];
  int err_count = 0, n_tests = 0;
  scr_row_t rows [18] = '{'{3'h1, 10'h001, 10'h001}, '{3'h1, 10'h002, 10'h002},
    '{3'h1, 10'h003, 10'h003}, '{3'h3, 10'h001, 10'h001}, '{3'h3, 10'h002, 10'h002},
    '{3'h3, 10'h003, 10'h003}, '{3'h4, 10'h001, 10'h001}, '{3'h4, 10'h002, 10'h002},
    '{3'h4, 10'h003, 10'h003}, '{3'h4, 10'h000, 10'h000}, '{3'h0, 10'h000, 10'h000},
    '{3'h0, 10'h002, 10'h002}, '{3'h0, 10'h001, 10'h001}, '{3'h6, 10'h0FF, 10'h0FF},
    '{3'h7, 10'h3A5, 10'h0A5}, '{3'h2, 10'h007, 10'h007}, '{3'h2, 10'h3FA, 10'h002},
    '{3'h5, 10'h3FF, 10'h3FF}};
  scr_serial_regs uut (.clk_sys, .sys_rst, .serial_select_line, .serial_shift_clock,
    .serial_data_line_in, .serial_data_line_out, .serial_data_line_oe, .operating_mode,
    .output_mode, .power_mode, .clamp_level, .gain_code, .first_aux_output_code,
    .second_aux_output_code, .offset_correction_enable, .gain_source_select,
    .aux_converter_power, .image_sensor_mode, .aux_video_mode, .direct_adc_mode, .aux_gain_code,
    .test_pattern_enable, .test_pattern, .data_outputs_hiz, .high_speed_aux,
    .reference_standby, .total_shutdown, .clamp_target_lsb);
  scr_host_model host (.clk_sys, .serial_data_line_wire(serial_data_line_in), .serial_select_line,
    .serial_shift_clock, .host_data, .host_oe);
  // A released data wire toggles every cycle, so stale bits cannot pass for read data.
  assign serial_data_line_in = serial_data_line_oe === 1'b1 ? serial_data_line_out
    : (host_oe ? host_data : idle_toggle);
  always @(negedge clk_sys) idle_toggle <= !idle_toggle;
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = !clk_sys;
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [9:0] reg_port(input logic [2:0] a);
    case (a)
      3'h0: return {8'h00, operating_mode};
      3'h1: return {8'h00, output_mode};
      3'h2: return {7'h00, aux_converter_power, gain_source_select, offset_correction_enable};
      3'h3: return {8'h00, power_mode};
      3'h4: return {8'h00, clamp_level};
      3'h5: return gain_code;
      3'h6: return {2'h0, first_aux_output_code};
      default: return {2'h0, second_aux_output_code};
    endcase
  endfunction
  // Decoded controls are worked out from the shadow copies of the coded registers.
  task automatic check_decode;
    logic [1:0] m, o, p, c;
    m = shadow[0][1:0];
    o = shadow[1][1:0];
    p = shadow[3][1:0];
    c = shadow[4][1:0];
    chk(10'({image_sensor_mode, aux_video_mode, direct_adc_mode}),
      10'({m[1], m == 1, m == 0}));
    chk(test_pattern, o == 1 ? 10'h155 : (o == 2 ? 10'h2AA : 10'h000));
    chk(10'({test_pattern_enable, data_outputs_hiz}), 10'({^o, &o}));
    chk(10'({high_speed_aux, reference_standby, total_shutdown}),
      10'({p == 1, p == 2, &p}));
    chk(10'(clamp_target_lsb),
      10'(c[1] ? (c[0] ? 7'h10 : 7'h40) : (c[0] ? 7'h30 : 7'h20)));
    chk(10'(aux_gain_code), 10'(shadow[5][9:2]));
  endtask
  // Write, then compare the port and a ten-bit readback with the expected contents.
  task automatic wr_chk(input logic [2:0] a, input logic [9:0] d, input int nd, input logic [9:0] r);
    host.frame(1'b0, a, d, nd, q);
    shadow[a] = r;
    chk(reg_port(a), r);
    host.frame(1'b1, a, 10'h000, 10, q);
    chk(q, r);
    check_decode();
  endtask
  task automatic reset_chk;
    sys_rst = 1'b1;
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    foreach (shadow[i]) shadow[i] = 10'h000;
    shadow[0] = 10'h003;
    repeat (4) @(negedge clk_sys);
    for (int a = 0; a < 8; a++)
    begin
      host.frame(1'b1, a[2:0], 10'h000, 10, q);
      chk(q, shadow[a]);
      chk(reg_port(a[2:0]), shadow[a]);
    end
    check_decode();
  endtask
  initial
  begin
    reset_chk();
    foreach (rows[i]) wr_chk(rows[i].a, rows[i].d, 10, rows[i].r);
    wr_chk(3'h5, 10'h0C3, 8, 10'h30F);
    wr_chk(3'h6, 10'h012, 8, 10'h0FF);
    wr_chk(3'h0, 10'h002, 10, 10'h002);
    wr_chk(3'h5, 10'h055, 8, 10'h30F);
    wr_chk(3'h7, 10'h05A, 12, 10'h05A);
    reset_chk();
    test_done();
  end
  initial
  begin
    #1ms;
    err_count++;
    test_done();
  end
endmodule
